// file: logic/sml_link.sv
// Purpose: Serial character and message layers of the remote link
// Assumes: rx_i synchronous to core_clk_i, idles high
// Notes:   Responses are supplied by the instrument core
`timescale 1ns/1ps
`include "sml_map.svh"
module sml_link
  import sml_pkg::*;
(
  // Clock and reset
  input  wire logic           core_clk_i,
  input  wire logic           rst_b_i,
  // Serial pins
  input  wire logic           rx_i,
  output logic                tx_o,
  // Received message characters toward the core
  output logic                msg_valid_o,
  input  wire logic           msg_ready_i,
  output sml_rx_msg_type      msg_o,
  // Response body characters from the core
  input  wire logic           rsp_valid_i,
  output logic                rsp_ready_o,
  input  wire sml_tx_chr_type rsp_i,
  // Status
  output logic                query_pending_o,
  output logic                char_err_o,
  output logic                overflow_o
);
  localparam logic [9:0] BIT_CYC  = 10'(`SML_BIT_CYC);
  localparam logic [9:0] HALF_CYC = 10'(`SML_HALF_CYC);

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_START = 4'h2, RX_BITS = 4'h4, RX_STOP = 4'h8
  } sml_rxs_type;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h1, TX_SHIFT = 3'h2, TX_PAUSE = 3'h4
  } sml_txs_type;
  typedef enum logic [2:0] {
    RS_BODY = 3'h1, RS_CR = 3'h2, RS_LF = 3'h4
  } sml_rss_type;

  typedef struct packed {
    sml_rxs_type rxs;
    logic [9:0]  rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic [7:0]  len;
    logic        drop;
    logic        is_q;
    logic        qpend;
    sml_txs_type txs;
    logic [9:0]  tx_cnt;
    logic [3:0]  tx_bit;
    logic [9:0]  tx_sh;
    sml_rss_type rss;
    logic        tx;
    logic        err;
    logic        ovf;
  } sml_st_type;

  sml_st_type     st_q, st_d;
  logic           f_in_valid;
  logic           f_in_ready;
  sml_rx_msg_type f_in_data;
  logic           tx_take;
  logic [6:0]     tx_ch;
  logic           tx_src;

  // Received characters buffered toward the core
  sml_fifo #(
    .WIDTH ($bits(sml_rx_msg_type)),
    .DEPTH (`SML_FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (msg_valid_o),
    .out_ready_i (msg_ready_i),
    .out_data_o  (msg_o)
  );

  // Response character source: body, then CR, then LF
  always_comb begin
    tx_src = 1'b0;
    tx_ch  = rsp_i.ch;
    case (st_q.rss)
      RS_BODY: tx_src = rsp_valid_i & st_q.qpend;
      RS_CR: begin
        tx_src = 1'b1;
        tx_ch  = `SML_CH_CR;
      end
      RS_LF: begin
        tx_src = 1'b1;
        tx_ch  = `SML_CH_LF;
      end
      default: tx_src = 1'b0;
    endcase
  end
  assign tx_take     = tx_src & (st_q.txs == TX_IDLE);
  assign rsp_ready_o = tx_take & (st_q.rss == RS_BODY);

  always_comb begin
    logic [6:0] c;
    logic       good;
    logic       term;
    logic       q_set;
    c           = st_q.rx_sh[6:0];
    good        = 1'b0;
    term        = 1'b0;
    q_set       = 1'b0;
    st_d        = st_q;
    f_in_valid  = 1'b0;
    f_in_data   = '0;
    // Receiver, fixed bit time
    case (st_q.rxs)
      RX_IDLE: if (!rx_i) begin
        st_d.rxs    = RX_START;
        st_d.rx_cnt = HALF_CYC;
      end
      RX_START: if (st_q.rx_cnt == 10'h000) begin
        st_d.rxs    = rx_i ? RX_IDLE : RX_BITS;
        st_d.rx_cnt = BIT_CYC - 10'h001;
        st_d.rx_bit = 4'h0;
      end else st_d.rx_cnt = st_q.rx_cnt - 10'h001;
      RX_BITS: if (st_q.rx_cnt == 10'h000) begin
        st_d.rx_sh  = {rx_i, st_q.rx_sh[7:1]};
        st_d.rx_cnt = BIT_CYC - 10'h001;
        st_d.rx_bit = st_q.rx_bit + 4'h1;
        if (st_q.rx_bit == 4'(`SML_DATA_BITS)) st_d.rxs = RX_STOP;
      end else st_d.rx_cnt = st_q.rx_cnt - 10'h001;
      RX_STOP: if (st_q.rx_cnt == 10'h000) begin
        st_d.rxs = RX_IDLE;
        good = rx_i & (^st_q.rx_sh);
        st_d.err = ~good;
      end else st_d.rx_cnt = st_q.rx_cnt - 10'h001;
      default: st_d.rxs = RX_IDLE;
    endcase
    // Message layer
    if (good) begin
      term = (c == `SML_CH_LF);
      if (term) begin
        if (!st_q.drop && st_q.len != 8'h00) begin
          f_in_valid     = 1'b1;
          f_in_data.ch   = `SML_CH_LF;
          f_in_data.last = 1'b1;
          f_in_data.query = st_q.is_q;
        end
        q_set        = st_q.is_q & ~st_q.drop;
        st_d.qpend   = st_q.qpend | q_set;
        st_d.len     = 8'h00;
        st_d.drop    = 1'b0;
        st_d.is_q    = 1'b0;
      end else if (c != `SML_CH_CR) begin
        if (st_q.len == 8'(`SML_MAX_CHARS) || !f_in_ready) begin
          st_d.drop = 1'b1;
          st_d.ovf  = 1'b1;
        end else if (!st_q.drop) begin
          st_d.len        = st_q.len + 8'h01;
          f_in_valid      = 1'b1;
          f_in_data.ch    = c;
          f_in_data.last  = (c == `SML_CH_SEMI);
          f_in_data.query = st_q.is_q | (c == `SML_CH_QMARK);
          if (c == `SML_CH_QMARK) st_d.is_q = 1'b1;
          if (c == `SML_CH_SEMI) begin
            q_set      = st_q.is_q;
            st_d.qpend = st_q.qpend | q_set;
            st_d.is_q  = 1'b0;
          end
        end
      end
    end
    // Transmitter, start + 7 data + odd parity + stop
    case (st_q.txs)
      TX_IDLE: if (tx_take) begin
        st_d.txs    = TX_SHIFT;
        st_d.tx_sh  = {1'b1, ~(^tx_ch), tx_ch, 1'b0};
        st_d.tx_cnt = BIT_CYC - 10'h001;
        st_d.tx_bit = 4'h0;
        st_d.tx     = 1'b0;
        case (st_q.rss)
          RS_BODY: if (rsp_i.last) st_d.rss = RS_CR;
          RS_CR: st_d.rss = RS_LF;
          default: begin
            st_d.rss   = RS_BODY;
            st_d.qpend = q_set;
          end
        endcase
      end
      TX_SHIFT: if (st_q.tx_cnt == 10'h000) begin
        st_d.tx_cnt = BIT_CYC - 10'h001;
        st_d.tx_bit = st_q.tx_bit + 4'h1;
        st_d.tx_sh  = {1'b1, st_q.tx_sh[9:1]};
        st_d.tx     = st_q.tx_sh[1];
        if (st_q.tx_bit == 4'h9) begin
          st_d.txs = TX_IDLE;
          st_d.tx  = 1'b1;
        end
      end else st_d.tx_cnt = st_q.tx_cnt - 10'h001;
      default: st_d.txs = TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q     <= '0;
      st_q.rxs <= RX_IDLE;
      st_q.txs <= TX_IDLE;
      st_q.rss <= RS_BODY;
      st_q.tx  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign tx_o            = st_q.tx;
  assign query_pending_o = st_q.qpend;
  assign char_err_o      = st_q.err;
  assign overflow_o      = st_q.ovf;
endmodule

// file: logic/sml_map.svh
// Purpose: Named constants for the serial message link
// Assumes: 10 MHz core clock
// Notes:   Times and rates in their own units, cycles derived
`ifndef SML_MAP_SVH
`define SML_MAP_SVH
`define SML_CLK_HZ      10000000
`define SML_BAUD        57600
`define SML_BIT_CYC     (`SML_CLK_HZ / `SML_BAUD)
`define SML_HALF_CYC    (`SML_BIT_CYC / 2)
`define SML_DATA_BITS   7
`define SML_MAX_CHARS   255
`define SML_CH_LF       7'h0a
`define SML_CH_CR       7'h0d
`define SML_CH_SEMI     7'h3b
`define SML_CH_QMARK    7'h3f
`define SML_CH_SPACE    7'h20
`define SML_FIFO_DEPTH  32
`endif

// file: logic/sml_pkg.sv
// Purpose: Types for the serial message link
// Assumes: Included map header supplies constants
// Notes:   Types only
package sml_pkg;
  typedef struct packed {
    logic [6:0] ch;
    logic       last;
    logic       query;
  } sml_rx_msg_type;

  typedef struct packed {
    logic [6:0] ch;
    logic       last;
  } sml_tx_chr_type;
endpackage

// file: logic/sml_fifo.sv
// Purpose: Generic synchronous FIFO with valid/ready on both sides
// Assumes: One clock, asynchronous active-low reset
// Notes:   Full and empty are exact
`timescale 1ns/1ps
module sml_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } sml_fifo_st_type;
  sml_fifo_st_type   st_q, st_d;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic              push;
  logic              pop;

  assign in_ready_o  = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_q.cnt != '0);
  assign out_data_o  = mem[st_q.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    st_d = st_q;
    if (push) st_d.wp = st_q.wp + 1'b1;
    if (pop) st_d.rp = st_q.rp + 1'b1;
    if (push & ~pop) st_d.cnt = st_q.cnt + 1'b1;
    else if (pop & ~push) st_d.cnt = st_q.cnt - 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) st_q <= '0;
    else st_q <= st_d;
  end

  always_ff @(posedge core_clk_i) begin
    if (push) mem[st_q.wp] <= in_data_i;
  end
endmodule

// file: dv/sml_link_asserts.sv
// Purpose: Port checks for sml_link
// Assumes: Bound to every sml_link
// Notes:   Ports only
`timescale 1ns/1ps
`include "sml_map.svh"
module sml_link_asserts
  import sml_pkg::*;
(
  // Watched ports
  input wire logic           core_clk_i,
  input wire logic           rst_b_i,
  input wire logic           tx_o,
  input wire logic           msg_valid_o,
  input wire logic           msg_ready_i,
  input wire sml_rx_msg_type msg_o,
  input wire logic           rsp_valid_i,
  input wire logic           rsp_ready_o,
  input wire logic           query_pending_o,
  input wire logic           char_err_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_rsp_on_query: assert property (
    rsp_ready_o |-> query_pending_o) else $error("reply, no query");
  a_rsp_on_valid: assert property (
    rsp_ready_o |-> rsp_valid_i) else $error("reply not offered");
  a_start_next: assert property (
    rsp_ready_o |=> !tx_o) else $error("late start bit");
  a_start_len: assert property (
    $fell(tx_o) |-> !tx_o [*8]) else $error("short start bit");
  a_msg_hold: assert property (
    msg_valid_o && !msg_ready_i |=> msg_valid_o && $stable(msg_o))
    else $error("char lost");
  a_no_cr: assert property (
    msg_valid_o |-> msg_o.ch != `SML_CH_CR) else $error("CR kept");
  a_last_term: assert property (
    msg_valid_o |-> msg_o.last == (msg_o.ch inside
    {`SML_CH_LF, `SML_CH_SEMI})) else $error("bad last");
  a_qmark_flag: assert property (
    msg_valid_o && msg_o.ch == `SML_CH_QMARK |-> msg_o.query)
    else $error("no query flag");
  c_reply: cover property (rsp_ready_o);
  c_term: cover property (msg_valid_o && msg_ready_i && msg_o.last);
  c_err: cover property ($rose(char_err_o));
endmodule

bind sml_link sml_link_asserts sml_link_asserts_i (.core_clk_i, .rst_b_i,
  .tx_o, .msg_valid_o, .msg_ready_i, .msg_o, .rsp_valid_i, .rsp_ready_o,
  .query_pending_o, .char_err_o);

// file: dv/sml_host.sv
// Purpose: Host side of the serial link
// Assumes: Device tx idles high
// Notes:   Sends by task, decodes into a queue
`timescale 1ns/1ps
`include "sml_map.svh"
module sml_host (
  // Clock and serial pins
  input  wire logic core_clk_i,
  input  wire logic tx_i,
  output logic      rx_o
);
  localparam int BIT   = `SML_BIT_CYC;
  localparam int QUIET = 100;
  logic [8:0] got[$];
  logic [9:0] r;

  initial rx_o = 1'b1;

  // Start, 7 data LSB first, odd parity, stop
  task automatic send(input string s, input logic bad, input logic stop);
    logic [6:0] c;
    logic [9:0] f;
    for (int k = 0; k < s.len(); k++) begin
      c = 7'(s[k]);
      f = {stop, ~^c ^ bad, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
        @(posedge core_clk_i);
        #1 rx_o = f[i];
        repeat (BIT - 1) @(posedge core_clk_i);
      end
      @(posedge core_clk_i);
      #1 rx_o = 1'b1;
      if (!stop) repeat (BIT) @(posedge core_clk_i);
    end
    // Quiet line after each transmission, device never times it
    repeat (QUIET) @(posedge core_clk_i);
  endtask

  // Mid-bit sampling, keeps {stop ok, odd, data}
  always begin
    @(negedge tx_i);
    repeat (BIT / 2) @(posedge core_clk_i);
    for (int i = 0; i < 10; i++) begin
      r[i] = tx_i;
      if (i < 9) repeat (BIT) @(posedge core_clk_i);
    end
    got.push_back({r[9] & ~r[0], ^r[8:1], r[7:1]});
  end
endmodule

// file: dv/sml_link_tb.sv
// Purpose: Self-checking bench for sml_link
// Assumes: sml_host drives rx, decodes tx
// Notes:   Buffer fill runs last
`timescale 1ns/1ps
`include "sml_map.svh"
module sml_link_tb
  import sml_pkg::*;
();
  logic           clk, rst_b, rx, tx, mv, mr, rv, rr, pend, err, ovf;
  sml_rx_msg_type msg;
  sml_tx_chr_type rsp;
  int             checks, n_mismatch, n;

  sml_link sml_link_i (.core_clk_i(clk), .rst_b_i(rst_b), .rx_i(rx),
    .tx_o(tx), .msg_valid_o(mv), .msg_ready_i(mr), .msg_o(msg),
    .rsp_valid_i(rv), .rsp_ready_o(rr), .rsp_i(rsp),
    .query_pending_o(pend), .char_err_o(err), .overflow_o(ovf));
  sml_host sml_host_i (.core_clk_i(clk), .tx_i(tx), .rx_o(rx));

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Read back: CR dropped, last on ; or LF
  task automatic take(input string s);
    logic [6:0] c;
    logic       q;
    q = 1'b0;
    for (int i = 0; i < s.len(); i++) begin
      c = 7'(s[i]);
      q |= c == `SML_CH_QMARK;
      if (c == `SML_CH_CR) continue;
      n = 0;
      do begin
        @(posedge clk);
        #1;
      end while (mv !== 1'b1 && ++n < 4000);
      chk(msg, {c, c inside {`SML_CH_LF, `SML_CH_SEMI}, q});
      mr = 1'b1;
      @(posedge clk);
      #1 mr = 1'b0;
      q &= c != `SML_CH_SEMI;
    end
  endtask

  task automatic reply(input logic [6:0] c, input logic l);
    rv = 1'b1;
    rsp = {c, l};
    n = 0;
    do @(negedge clk); while (rr !== 1'b1 && ++n < 5000);
    @(posedge clk);
    #1;
  endtask

  // Command alone: no pending query, no reply
  task automatic t_cmd;
    rv = 1'b1;
    sml_host_i.send("C 1\n", 1'b0, 1'b1);
    take("C 1\n");
    chk({8'h00, pend}, 9'h000);
    chk(9'(sml_host_i.got.size()), 9'h000);
    rv = 1'b0;
  endtask

  // Chained strings, CR LF end, reply closed by CR LF
  task automatic t_query;
    sml_host_i.send("D;E?\r\n", 1'b0, 1'b1);
    take("D;E?\r\n");
    chk({8'h00, pend}, 9'h001);
    reply(7'h34, 1'b0);
    chk({8'h00, n < 3}, 9'h001);
    reply(7'h32, 1'b1);
    rv = 1'b0;
    for (n = 0; sml_host_i.got.size() < 4 && n < 9000; n++) @(posedge clk);
    #1;
    chk(sml_host_i.got[0], 9'h1b4);
    chk(sml_host_i.got[1], 9'h1b2);
    chk(sml_host_i.got[2], {2'b11, `SML_CH_CR});
    chk(sml_host_i.got[3], {2'b11, `SML_CH_LF});
    chk({8'h00, pend}, 9'h000);
  endtask

  // Bad parity, missing stop: dropped and flagged
  task automatic t_bad;
    sml_host_i.send("X", 1'b1, 1'b1);
    chk({8'h00, err}, 9'h001);
    sml_host_i.send("Y", 1'b0, 1'b0);
    chk({8'h00, err}, 9'h001);
    sml_host_i.send("K\n", 1'b0, 1'b1);
    take("K\n");
    chk({8'h00, err}, 9'h000);
  endtask

  // Core stalls: fill buffer, overflow, drain, resume after LF
  task automatic t_fifo;
    string s;
    s = "B";
    repeat (`SML_FIFO_DEPTH) s = {"A", s};
    sml_host_i.send(s, 1'b0, 1'b1);
    chk({8'h00, ovf}, 9'h001);
    repeat (`SML_FIFO_DEPTH) take("A");
    chk({8'h00, mv}, 9'h000);
    sml_host_i.send("\nM\n", 1'b0, 1'b1);
    take("M\n");
    chk({8'h00, mv}, 9'h000);
  endtask

  task automatic close_out;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    rst_b = 1'b0;
    mr = 1'b0;
    rv = 1'b0;
    rsp = '0;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    t_cmd();
    t_query();
    t_bad();
    t_fifo();
    close_out();
  end
endmodule
